//--- rtl/bcr_pkg.sv
/*
  bcr_pkg: register map, field layout, reset values and decode tables for the
  step-down converter configuration register group.
  Assumes an 8-bit register port driven by the serial-interface front end.
*/
package bcr_pkg;
  localparam logic [7:0] BCR_OFS_C0_LIMIT_RAMP = 8'h03;
  localparam logic [7:0] BCR_OFS_C1_ENABLE_MODE = 8'h04;
  localparam logic [7:0] BCR_OFS_C1_LIMIT_RAMP = 8'h05;
  localparam logic [7:0] BCR_OFS_C0_SETPOINT = 8'h06;

  localparam logic [7:0] BCR_RST_C0_LIMIT_RAMP = 8'h1A;
  localparam logic [7:0] BCR_RST_C1_ENABLE_MODE = 8'h07;
  localparam logic [7:0] BCR_RST_C1_LIMIT_RAMP = 8'h1B;
  localparam logic [7:0] BCR_RST_C0_SETPOINT = 8'hB1;

  localparam int BCR_LIM_LSB = 3;
  localparam int BCR_RAMP_LSB = 0;
  localparam int BCR_FPWM_BIT = 3;
  localparam int BCR_DIS_BIT = 2;
  localparam int BCR_PIN_BIT = 1;
  localparam int BCR_EN_BIT = 0;

  // setpoint segment boundaries and bases, output in millivolts
  localparam logic [7:0] BCR_SEG1_LO = 8'h14;
  localparam logic [7:0] BCR_SEG2_LO = 8'h18;
  localparam logic [7:0] BCR_SEG3_LO = 8'h9E;
  localparam logic [11:0] BCR_SEG1_BASE_MV = 12'h2BC;
  localparam logic [11:0] BCR_SEG2_BASE_MV = 12'h2DF;
  localparam logic [11:0] BCR_SEG3_BASE_MV = 12'h58C;
  localparam logic [11:0] BCR_SEG1_STEP_MV = 12'h00A;
  localparam logic [11:0] BCR_SEG2_STEP_MV = 12'h005;
  localparam logic [11:0] BCR_SEG3_STEP_MV = 12'h014;

  // current limit in units of 0.5 A; 1.5 A is 3
  localparam logic [3:0] BCR_LIM_BASE_HALF_A = 4'h3;
  // ramp rate in units of 0.01 mV/us indexed by code
  localparam logic [9:0] BCR_RAMP_TABLE [8] = '{10'h000, 10'h000, 10'h3E8, 10'h2EE,
                                               10'h17C, 10'h0BE, 10'h05E, 10'h02F};

  typedef struct packed {
    logic [3:0] limit_half_a;
    logic [9:0] ramp_centi_mv_us;
    logic ramp_both_edges;
  } bcr_conv_ctl_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bcr_reg_req_t;
endpackage

//--- rtl/bcr_regs.sv
/*
  bcr_regs: the four converter configuration registers and their decoded
  controls for the analog regulator.
  Assumes register writes and reads come from the serial-interface front end
  on the same clock; only the external enable pin is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module bcr_regs import bcr_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire bcr_reg_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_addr_hit,
  input wire logic i_en_pin,
  output bcr_conv_ctl_t o_conv0_ctl,
  output bcr_conv_ctl_t o_conv1_ctl,
  output logic [11:0] o_conv0_setpoint_mv,
  output logic o_conv1_run,
  output logic o_conv1_forced_pulse_width,
  output logic o_conv1_discharge_on
);
  logic [7:0] c0_lr_q;
  logic [7:0] c1_em_q;
  logic [7:0] c1_lr_q;
  logic [7:0] c0_sp_q;
  logic [2:0] pin_sync_q;
  logic pin_level_q;
  bcr_conv_ctl_t c0_ctl_q;
  bcr_conv_ctl_t c1_ctl_q;
  logic [11:0] sp_mv_q;
  logic c1_run_q;
  logic c1_fpwm_q;
  logic c1_dis_q;

  wire sel_c0_lr = i_req.addr == BCR_OFS_C0_LIMIT_RAMP;
  wire sel_c1_em = i_req.addr == BCR_OFS_C1_ENABLE_MODE;
  wire sel_c1_lr = i_req.addr == BCR_OFS_C1_LIMIT_RAMP;
  wire sel_c0_sp = i_req.addr == BCR_OFS_C0_SETPOINT;
  assign o_addr_hit = sel_c0_lr | sel_c1_em | sel_c1_lr | sel_c0_sp;
  // full byte readback, reserved bits included
  assign o_rdata = sel_c0_lr ? c0_lr_q : sel_c1_em ? c1_em_q :
                   sel_c1_lr ? c1_lr_q : sel_c0_sp ? c0_sp_q : 8'h00;

  // register writes take effect at any time, even while running
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      c0_lr_q <= BCR_RST_C0_LIMIT_RAMP;
      c1_em_q <= BCR_RST_C1_ENABLE_MODE;
      c1_lr_q <= BCR_RST_C1_LIMIT_RAMP;
      c0_sp_q <= BCR_RST_C0_SETPOINT;
    end else if (i_req.wr) begin
      if (sel_c0_lr) c0_lr_q <= i_req.wdata;
      if (sel_c1_em) c1_em_q <= i_req.wdata;
      if (sel_c1_lr) c1_lr_q <= i_req.wdata;
      if (sel_c0_sp) c0_sp_q <= i_req.wdata;
    end
  end

  // pin is asynchronous: three stages, change taken when last two agree
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pin_sync_q <= 3'h0;
      pin_level_q <= 1'b0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], i_en_pin};
      if (pin_sync_q[1] == pin_sync_q[2]) pin_level_q <= pin_sync_q[2];
    end
  end

  // checks wait one edge past release: the first decode still holds reset zeros
  logic live_q;
  always_ff @(posedge i_sys_clk) begin
    live_q <= i_rst_n;
  end

  wire [2:0] c0_lim_code = c0_lr_q[BCR_LIM_LSB +: 3];
  wire [2:0] c1_lim_code = c1_lr_q[BCR_LIM_LSB +: 3];
  wire [2:0] c0_ramp_code = c0_lr_q[BCR_RAMP_LSB +: 3];
  wire [2:0] c1_ramp_code = c1_lr_q[BCR_RAMP_LSB +: 3];
  // codes 4..7 are reserved; the host keeps off them, so only low bits decode
  wire [3:0] c0_lim_d = BCR_LIM_BASE_HALF_A + {2'h0, c0_lim_code[1:0]};
  wire [3:0] c1_lim_d = BCR_LIM_BASE_HALF_A + {2'h0, c1_lim_code[1:0]};
  // reserved ramp codes 0 and 1 decode to zero rate, host must avoid them
  wire [9:0] c0_ramp_d = BCR_RAMP_TABLE[c0_ramp_code];
  wire [9:0] c1_ramp_d = BCR_RAMP_TABLE[c1_ramp_code];

  wire [7:0] sp_code = c0_sp_q;
  wire [11:0] sp_off1 = 12'(sp_code - BCR_SEG1_LO);
  wire [11:0] sp_off2 = 12'(sp_code - BCR_SEG2_LO);
  wire [11:0] sp_off3 = 12'(sp_code - BCR_SEG3_LO);
  wire [11:0] sp_mv1 = 12'(BCR_SEG1_BASE_MV + sp_off1 * BCR_SEG1_STEP_MV);
  wire [11:0] sp_mv2 = 12'(BCR_SEG2_BASE_MV + sp_off2 * BCR_SEG2_STEP_MV);
  wire [11:0] sp_mv3 = 12'(BCR_SEG3_BASE_MV + sp_off3 * BCR_SEG3_STEP_MV);
  // codes below 0x14 are reserved; clamp to the lowest point rather than wrap
  wire [11:0] sp_mv_d = (sp_code >= BCR_SEG3_LO) ? sp_mv3 :
                        (sp_code >= BCR_SEG2_LO) ? sp_mv2 :
                        (sp_code >= BCR_SEG1_LO) ? sp_mv1 : BCR_SEG1_BASE_MV;

  wire c1_soft_en = c1_em_q[BCR_EN_BIT];
  wire c1_pin_gate = c1_em_q[BCR_PIN_BIT];
  wire c1_run_d = c1_soft_en & (~c1_pin_gate | pin_level_q);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      c0_ctl_q <= '0;
      c1_ctl_q <= '0;
      sp_mv_q <= '0;
      c1_run_q <= 1'b0;
      c1_fpwm_q <= 1'b0;
      c1_dis_q <= 1'b0;
    end else begin
      c0_ctl_q <= '{limit_half_a: c0_lim_d, ramp_centi_mv_us: c0_ramp_d, ramp_both_edges: 1'b1};
      c1_ctl_q <= '{limit_half_a: c1_lim_d, ramp_centi_mv_us: c1_ramp_d, ramp_both_edges: 1'b1};
      sp_mv_q <= sp_mv_d;
      c1_run_q <= c1_run_d;
      c1_fpwm_q <= c1_em_q[BCR_FPWM_BIT];
      c1_dis_q <= c1_em_q[BCR_DIS_BIT] & ~c1_run_d;
    end
  end

  assign o_conv0_ctl = c0_ctl_q;
  assign o_conv1_ctl = c1_ctl_q;
  assign o_conv0_setpoint_mv = sp_mv_q;
  assign o_conv1_run = c1_run_q;
  assign o_conv1_forced_pulse_width = c1_fpwm_q;
  assign o_conv1_discharge_on = c1_dis_q;

  a_limit_map: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    1'b1 |=> o_conv0_ctl.limit_half_a == 4'(BCR_LIM_BASE_HALF_A + {2'h0, $past(c0_lr_q[4:3])}))
    else $error("converter 0 limit decode wrong");
  a_limit_same: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    (c0_lr_q[5:3] == c1_lr_q[5:3]) |=> o_conv0_ctl.limit_half_a == o_conv1_ctl.limit_half_a)
    else $error("converter limit tables differ");
  a_limit_live: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    (i_req.wr && sel_c0_lr && c1_run_q) |=> ##1 o_conv0_ctl.limit_half_a ==
      4'(BCR_LIM_BASE_HALF_A + {2'h0, $past(i_req.wdata[4:3], 2)}))
    else $error("live limit write not applied");
  a_ramp_fast: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    (c0_lr_q[2:0] == 3'h2) |=> o_conv0_ctl.ramp_centi_mv_us == 10'h3E8)
    else $error("ramp code 2 not 10 mV/us");
  a_ramp_slow: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    (c1_lr_q[2:0] == 3'h7) |=> o_conv1_ctl.ramp_centi_mv_us == 10'h02F)
    else $error("ramp code 7 not 0.47 mV/us");
  a_ramp_edges: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    ##1 (o_conv0_ctl.ramp_both_edges && o_conv1_ctl.ramp_both_edges))
    else $error("ramp not applied to both edges");
  a_mode_bit: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    $rose(c1_em_q[BCR_FPWM_BIT]) |=> o_conv1_forced_pulse_width)
    else $error("forced pulse width not set");
  a_discharge: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    o_conv1_discharge_on |-> !o_conv1_run && $past(c1_em_q[BCR_DIS_BIT]))
    else $error("discharge while running or unset");
  a_pin_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    (c1_em_q[1:0] == 2'h3 && !pin_level_q) |=> !o_conv1_run)
    else $error("runs without enable pin");
  a_soft_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    (!c1_em_q[BCR_EN_BIT]) |=> !o_conv1_run)
    else $error("runs with soft enable clear");
  a_setpoint_lo: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    (c0_sp_q == 8'h17) |=> o_conv0_setpoint_mv == 12'h2DA)
    else $error("code 0x17 not 0.73 V");
  a_setpoint_mid: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    (c0_sp_q == 8'h9D) |=> o_conv0_setpoint_mv == 12'h578)
    else $error("code 0x9D not 1.4 V");
  a_setpoint_hi: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    (c0_sp_q == 8'hFF) |=> o_conv0_setpoint_mv == 12'hD20)
    else $error("code 0xFF not 3.36 V");
  a_reserved_keep: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n || !live_q)
    (i_req.wr && sel_c1_em) |=> c1_em_q == $past(i_req.wdata))
    else $error("reserved bits not stored");

  // registers come out of reset at their documented defaults
  a_rst_limit0: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    !$past(i_rst_n) |-> c0_lr_q == BCR_RST_C0_LIMIT_RAMP)
    else $error("converter 0 limit register reset wrong");
  a_rst_mode1: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    !$past(i_rst_n) |-> c1_em_q == BCR_RST_C1_ENABLE_MODE)
    else $error("converter 1 mode register reset wrong");
  a_rst_limit1: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    !$past(i_rst_n) |-> c1_lr_q == BCR_RST_C1_LIMIT_RAMP)
    else $error("converter 1 limit register reset wrong");
  a_rst_setpoint: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    !$past(i_rst_n) |-> c0_sp_q == BCR_RST_C0_SETPOINT)
    else $error("setpoint register reset wrong");

  // current limit decode, both converters
  a_limit_map1: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    1'b1 |=> o_conv1_ctl.limit_half_a == 4'(BCR_LIM_BASE_HALF_A + {2'h0, $past(c1_lr_q[4:3])}))
    else $error("converter 1 limit decode wrong");
  a_limit_min: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c0_lr_q[5:3] == 3'h0) |=> o_conv0_ctl.limit_half_a == 4'h3)
    else $error("limit code 0 not 1.5 A");
  a_limit_max: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c0_lr_q[5:3] == 3'h3) |=> o_conv0_ctl.limit_half_a == 4'h6)
    else $error("limit code 3 not 3.0 A");
  a_limit_two: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c1_lr_q[5:3] == 3'h1) |=> o_conv1_ctl.limit_half_a == 4'h4)
    else $error("limit code 1 not 2.0 A");
  a_limit_half: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c1_lr_q[5:3] == 3'h2) |=> o_conv1_ctl.limit_half_a == 4'h5)
    else $error("limit code 2 not 2.5 A");
  a_limit_live1: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (i_req.wr && sel_c1_lr && c1_run_q) |=> ##1 o_conv1_ctl.limit_half_a ==
      4'(BCR_LIM_BASE_HALF_A + {2'h0, $past(i_req.wdata[4:3], 2)}))
    else $error("live converter 1 limit write not applied");

  // ramp rate decode; a slow table lookup would show here first
  a_ramp_map0: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    1'b1 |=> o_conv0_ctl.ramp_centi_mv_us == BCR_RAMP_TABLE[$past(c0_lr_q[2:0])])
    else $error("converter 0 ramp decode wrong");
  a_ramp_map1: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    1'b1 |=> o_conv1_ctl.ramp_centi_mv_us == BCR_RAMP_TABLE[$past(c1_lr_q[2:0])])
    else $error("converter 1 ramp decode wrong");
  a_ramp_three: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c0_lr_q[2:0] == 3'h3) |=> o_conv0_ctl.ramp_centi_mv_us == 10'h2EE)
    else $error("ramp code 3 not 7.5 mV/us");
  a_ramp_four: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c0_lr_q[2:0] == 3'h4) |=> o_conv0_ctl.ramp_centi_mv_us == 10'h17C)
    else $error("ramp code 4 not 3.8 mV/us");
  a_ramp_five: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c0_lr_q[2:0] == 3'h5) |=> o_conv0_ctl.ramp_centi_mv_us == 10'h0BE)
    else $error("ramp code 5 not 1.9 mV/us");
  a_ramp_six: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c1_lr_q[2:0] == 3'h6) |=> o_conv1_ctl.ramp_centi_mv_us == 10'h05E)
    else $error("ramp code 6 not 0.94 mV/us");
  a_ramp_fast1: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c1_lr_q[2:0] == 3'h2) |=> o_conv1_ctl.ramp_centi_mv_us == 10'h3E8)
    else $error("converter 1 ramp code 2 not 10 mV/us");

  // converter 1 mode, discharge and enable
  a_mode_clear: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    $fell(c1_em_q[BCR_FPWM_BIT]) |=> !o_conv1_forced_pulse_width)
    else $error("forced pulse width not cleared");
  a_mode_follow: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    1'b1 |=> o_conv1_forced_pulse_width == $past(c1_em_q[BCR_FPWM_BIT]))
    else $error("mode output does not follow bit");
  a_discharge_on: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c1_em_q[BCR_DIS_BIT] && !c1_run_d) |=> o_conv1_discharge_on)
    else $error("discharge missing while disabled");
  a_discharge_off: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    !c1_em_q[BCR_DIS_BIT] |=> !o_conv1_discharge_on)
    else $error("discharge on with bit clear");
  a_soft_run: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c1_em_q[1:0] == 2'h1) |=> o_conv1_run)
    else $error("soft enable alone does not run");
  a_pin_run: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c1_em_q[1:0] == 2'h3 && pin_level_q) |=> o_conv1_run)
    else $error("enable pin and bit do not run");
  // a glitch shorter than two samples must not reach the enable decode
  a_pin_hold: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (pin_sync_q[1] != pin_sync_q[2]) |=> $stable(pin_level_q))
    else $error("pin level moved without agreement");
  a_pin_take: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (pin_sync_q[1] == pin_sync_q[2]) |=> pin_level_q == $past(pin_sync_q[2]))
    else $error("agreed pin level not taken");

  // setpoint segment starts and the reserved clamp
  a_setpoint_one: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c0_sp_q == 8'h14) |=> o_conv0_setpoint_mv == 12'h2BC)
    else $error("code 0x14 not 0.7 V");
  a_setpoint_two: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c0_sp_q == 8'h18) |=> o_conv0_setpoint_mv == 12'h2DF)
    else $error("code 0x18 not 0.735 V");
  a_setpoint_three: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c0_sp_q == 8'h9E) |=> o_conv0_setpoint_mv == 12'h58C)
    else $error("code 0x9E not 1.42 V");
  a_setpoint_clamp: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (c0_sp_q < BCR_SEG1_LO) |=> o_conv0_setpoint_mv == 12'h2BC)
    else $error("reserved setpoint not clamped");

  // write path and unmapped accesses
  a_write_limit0: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (i_req.wr && sel_c0_lr) |=> c0_lr_q == $past(i_req.wdata))
    else $error("converter 0 limit byte not stored");
  a_write_limit1: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (i_req.wr && sel_c1_lr) |=> c1_lr_q == $past(i_req.wdata))
    else $error("converter 1 limit byte not stored");
  a_write_setpoint: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (i_req.wr && sel_c0_sp) |=> c0_sp_q == $past(i_req.wdata))
    else $error("setpoint byte not stored");
  a_miss_quiet: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    (i_req.wr && !o_addr_hit) |=> $stable(c0_lr_q) && $stable(c1_em_q) && $stable(c1_lr_q) && $stable(c0_sp_q))
    else $error("unmapped write changed a register");
  a_miss_zero: assert property (@(posedge i_sys_clk)
    disable iff (!i_rst_n || !live_q)
    !o_addr_hit |-> o_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

//--- test/bcr_host_model.sv
/*
  bcr_host_model: register-port master standing in for the serial front end.
  Assumes a free-running clock; the bench calls its tasks hierarchically.
*/
`timescale 1ns/1ps
`default_nettype none
module bcr_host_model import bcr_pkg::*; (
  input wire logic i_sys_clk,
  output var bcr_reg_req_t o_req
);
  initial o_req = '0;
  // one-cycle strobe; the next call waits an edge, so wr never re-rises in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk) o_req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge i_sys_clk) o_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk) o_req <= '{wr: 1'b0, addr: a, wdata: 8'h00};
  endtask
endmodule
`default_nettype wire

//--- test/buck_converter_config_registers_bench.sv
/*
  Bench for bcr_regs: host model drives writes, a monitor pops noted results.
  Assumes the package offsets and one clock; the enable pin is driven freely.
*/
`timescale 1ns/1ps
`default_nettype none
module buck_converter_config_registers_bench import bcr_pkg::*;;
  typedef struct {int sel; logic [15:0] exp;} bcr_note_t;
  logic clk, rst_n, en_pin, chk, hit, run, fpwm, dis;
  logic [7:0] rdata;
  logic [11:0] mv;
  bcr_conv_ctl_t c0, c1;
  bcr_reg_req_t req;
  int n_errors = 0, n_compared = 0;
  logic [15:0] lfsr = 16'h9F93;
  bcr_note_t notes[$];
  localparam logic [9:0] RATE [8] = '{10'h000, 10'h000, 10'h3E8, 10'h2EE, 10'h17C, 10'h0BE, 10'h05E, 10'h02F};
  localparam logic [7:0] RST [4] = '{8'h1A, 8'h07, 8'h1B, 8'hB1};
  localparam string NAME [8] = '{"rdata", "addr_hit", "conv0", "conv1", "setpoint", "run", "fpwm", "discharge"};
  bcr_regs uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_req(req), .o_rdata(rdata), .o_addr_hit(hit),
    .i_en_pin(en_pin), .o_conv0_ctl(c0), .o_conv1_ctl(c1), .o_conv0_setpoint_mv(mv), .o_conv1_run(run),
    .o_conv1_forced_pulse_width(fpwm), .o_conv1_discharge_on(dis));
  bcr_host_model host (.i_sys_clk(clk), .o_req(req));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [15:0] mv_of(input logic [7:0] c);
    if (c < 8'h18) return 16'(700 + 10 * (c - 8'h14));
    if (c < 8'h9E) return 16'(735 + 5 * (c - 8'h18));
    return 16'(1420 + 20 * (c - 8'h9E));
  endfunction
  task automatic expect_val(input int sel, input logic [15:0] e);
    @(posedge clk) notes.push_back('{sel, e});
    chk <= 1'b1;
    @(posedge clk) chk <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // levels are steady between writes, so sampling before this edge's updates is safe
  always @(posedge clk) if (chk) begin
    bcr_note_t n;
    logic [15:0] got;
    n = notes.pop_front();
    case (n.sel)
      0: got = {8'h00, rdata};
      1: got = {15'h0000, hit};
      2: got = {1'b0, c0};
      3: got = {1'b0, c1};
      4: got = {4'h0, mv};
      5: got = {15'h0000, run};
      6: got = {15'h0000, fpwm};
      default: got = {15'h0000, dis};
    endcase
    n_compared++;
    if (got !== n.exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", NAME[n.sel], n.exp, got);
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    logic [7:0] b;
    logic e_run;
    logic [7:0] sp_last;
    rst_n = 1'b0;
    en_pin = 1'b0;
    chk = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.rd(BCR_OFS_C0_LIMIT_RAMP + 8'(i));
      expect_val(0, {8'h00, RST[i]});
      expect_val(1, 16'h0001);
    end
    expect_val(2, {1'b0, 4'h6, 10'h3E8, 1'b1});
    expect_val(3, {1'b0, 4'h6, 10'h2EE, 1'b1});
    expect_val(4, mv_of(8'hB1));
    expect_val(7, 16'h0001);
    en_pin <= 1'b1;
    // converter 1 stays running while its limit changes underneath
    for (int l = 0; l < 4; l++) for (int r = 2; r < 8; r++) for (int c = 0; c < 2; c++) begin
      b = {lfsr[7:6], 3'(l), 3'(r)};
      lfsr = nxt(lfsr);
      host.wr(c ? BCR_OFS_C1_LIMIT_RAMP : BCR_OFS_C0_LIMIT_RAMP, b);
      expect_val(2 + c, {1'b0, 4'(3 + l), RATE[r], 1'b1});
      expect_val(5, 16'h0001);
      host.rd(c ? BCR_OFS_C1_LIMIT_RAMP : BCR_OFS_C0_LIMIT_RAMP);
      expect_val(0, {8'h00, b});
    end
    for (int i = 0; i < 14; i++) begin
      b = i < 6 ? RST[0] : lfsr[7:0];
      case (i)
        0: b = 8'h14; 1: b = 8'h17; 2: b = 8'h18; 3: b = 8'h9D; 4: b = 8'h9E; 5: b = 8'hFF;
        default: if (b < 8'h14) b = 8'h14 + {4'h0, lfsr[3:0]};
      endcase
      lfsr = nxt(lfsr);
      host.wr(BCR_OFS_C0_SETPOINT, b);
      sp_last = b;
      expect_val(4, mv_of(b));
    end
    for (int k = 0; k < 32; k++) begin
      b = {lfsr[7:4], 4'(k)};
      lfsr = nxt(lfsr);
      en_pin <= k[4];
      host.wr(BCR_OFS_C1_ENABLE_MODE, b);
      repeat (8) @(posedge clk);
      e_run = b[0] & (~b[1] | k[4]);
      expect_val(5, {15'h0000, e_run});
      expect_val(6, {15'h0000, b[3]});
      expect_val(7, {15'h0000, b[2] & ~e_run});
      host.rd(BCR_OFS_C1_ENABLE_MODE);
      expect_val(0, {8'h00, b});
    end
    for (int i = 0; i < 4; i++) begin
      b = i[1] ? (i[0] ? 8'hFF : 8'h07) : (i[0] ? 8'h02 : 8'h00);
      host.wr(b, 8'h14);
      host.rd(b);
      expect_val(1, 16'h0000);
      expect_val(0, 16'h0000);
      expect_val(4, mv_of(sp_last));
    end
    repeat (2) @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
